// file: rtl/ansir_pkg.sv
// Constants and carrier types of the auto-negotiation status and interrupt registers
package ansir_pkg;

  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFS_PARTNER  = 8'hc8;
  localparam logic [APB_AW-1:0] OFS_EXPAND   = 8'hcc;
  localparam logic [APB_AW-1:0] OFS_MODE     = 8'hd0;
  localparam logic [APB_AW-1:0] OFS_STATUS   = 8'hd4;
  localparam logic [APB_AW-1:0] OFS_IRQ_EN   = 8'hd8;

  // Partner ability fields
  localparam int unsigned PA_NEXT_PAGE   = 15;
  localparam int unsigned PA_ACK         = 14;
  localparam int unsigned PA_RFAULT      = 13;
  localparam int unsigned PA_ABIL_HI     = 10;
  localparam int unsigned PA_ABIL_LO     = 5;
  localparam int unsigned PA_SEL_HI      = 4;
  localparam logic [4:0]  PA_SEL_RST     = 5'h01;

  // Expansion fields
  localparam int unsigned EX_PD_FAULT    = 4;
  localparam int unsigned EX_PARTNER_NXT = 3;
  localparam int unsigned EX_LOCAL_NXT   = 2;
  localparam int unsigned EX_PAGE_RX     = 1;
  localparam int unsigned EX_PARTNER_AN  = 0;

  // Mode control and status fields
  localparam int unsigned MC_LONG_SQ     = 11;
  localparam int unsigned ST_SPEED       = 9;
  localparam int unsigned ST_DUPLEX      = 8;
  localparam int unsigned ST_PAUSE       = 7;
  localparam int unsigned EV_N           = 7;
  localparam int unsigned EV_DONE        = 6;
  localparam int unsigned EV_RFAULT      = 5;
  localparam int unsigned EV_LINK_DOWN   = 4;
  localparam int unsigned EV_ACK         = 3;
  localparam int unsigned EV_PD_FAULT    = 2;
  localparam int unsigned EV_PAGE        = 1;
  localparam int unsigned EV_RXERR       = 0;

  // Receive error packets that raise the error-full event
  localparam logic [6:0]  ERR_LIMIT      = 7'h40;

  // One-cycle event pulses; field order gives status bits 6 down to 0
  typedef struct packed {
    logic autoneg_done_event;
    logic remote_fault_event;
    logic link_down_event;
    logic code_word_ack_event;
    logic parallel_detect_fault;
    logic page_received_event;
    logic rx_error_packet;
  } ansir_evt_t;

  // Resolved configuration levels
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic pause_enabled;
  } ansir_res_t;

endpackage

// file: rtl/ansir_regs.sv
// APB register bank for partner ability, expansion, mode control and interrupt status
`timescale 1ns/1ps

module ansir_regs
(
  // Clock, reset and freeze
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          ce,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ansir_pkg::APB_AW-1:0]  paddr,
  input  wire logic [ansir_pkg::APB_DW-1:0]  pwdata,
  output logic      [ansir_pkg::APB_DW-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Negotiation engine side
  input  wire logic [15:0]                   partner_code_word,
  input  wire ansir_pkg::ansir_evt_t         phy_events,
  input  wire ansir_pkg::ansir_res_t         phy_resolved,
  // Outputs to the transceiver and system
  output logic                               long_cable_squelch,
  output logic                               xcvr_irq
);

  typedef struct packed {
    logic        long_sq;
    logic [6:0]  irq_en;
    logic        lp_nxt;
    logic        lp_ack;
    logic        lp_rf;
    logic [5:0]  lp_abil;
    logic [4:0]  lp_sel;
    logic        lp_an;
    logic        exp_fault;
    logic        exp_page;
    logic [6:0]  stat;
    logic [6:0]  err_cnt;
    logic [31:0] rdata;
    logic        irq;
  } ansir_state_t;

  localparam ansir_state_t ST_RST = '{
    long_sq: 1'b0,
    irq_en:  7'h00,
    lp_nxt:    1'b0,
    lp_ack:    1'b0,
    lp_rf:     1'b0,
    lp_abil:   6'h00,
    lp_sel:    ansir_pkg::PA_SEL_RST,
    lp_an:     1'b0,
    exp_fault: 1'b0,
    exp_page:  1'b0,
    stat:    7'h00,
    err_cnt: 7'h00,
    rdata:   32'h0000_0000,
    irq:     1'b0
  };

  ansir_state_t st_ff;
  ansir_state_t nxt_st;

  logic        setup_ph;
  logic        access_ph;
  logic        mapped;
  logic        rd_take;
  logic        wr_take;
  logic [15:0] rd_mux;
  logic [6:0]  ev_vec;
  logic [6:0]  set_vec;
  logic        err_full;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped    = (paddr == ansir_pkg::OFS_PARTNER) || (paddr == ansir_pkg::OFS_EXPAND)
                  || (paddr == ansir_pkg::OFS_MODE) || (paddr == ansir_pkg::OFS_STATUS)
                  || (paddr == ansir_pkg::OFS_IRQ_EN);
  // A frozen block stretches the access phase rather than dropping it
  assign pready    = ce;
  assign pslverr   = access_ph && !mapped;
  assign rd_take   = ce && access_ph && !pwrite && mapped;
  assign wr_take   = ce && access_ph && pwrite && mapped;
  assign ev_vec    = phy_events;
  assign err_full  = phy_events.rx_error_packet && (st_ff.err_cnt == ansir_pkg::ERR_LIMIT - 7'h01);

  // Error-full replaces the raw receive error pulse in the latched set
  always_comb
  begin
    set_vec = ev_vec;
    set_vec[ansir_pkg::EV_RXERR] = err_full;
  end

  // Read view of the current registers
  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (paddr)
      ansir_pkg::OFS_PARTNER:
      begin
        rd_mux[ansir_pkg::PA_NEXT_PAGE] = st_ff.lp_nxt;
        rd_mux[ansir_pkg::PA_ACK]       = st_ff.lp_ack;
        rd_mux[ansir_pkg::PA_RFAULT]    = st_ff.lp_rf;
        rd_mux[ansir_pkg::PA_ABIL_HI:ansir_pkg::PA_ABIL_LO] = st_ff.lp_abil;
        rd_mux[ansir_pkg::PA_SEL_HI:0]  = st_ff.lp_sel;
      end
      ansir_pkg::OFS_EXPAND:
      begin
        rd_mux[ansir_pkg::EX_PD_FAULT]    = st_ff.exp_fault;
        rd_mux[ansir_pkg::EX_PARTNER_NXT] = st_ff.lp_nxt;
        rd_mux[ansir_pkg::EX_LOCAL_NXT]   = 1'b0;
        rd_mux[ansir_pkg::EX_PAGE_RX]     = st_ff.exp_page;
        rd_mux[ansir_pkg::EX_PARTNER_AN] = st_ff.lp_an;
      end
      ansir_pkg::OFS_MODE:
      begin
        rd_mux[ansir_pkg::MC_LONG_SQ] = st_ff.long_sq;
      end
      ansir_pkg::OFS_STATUS:
      begin
        rd_mux[ansir_pkg::ST_SPEED]  = phy_resolved.speed_100;
        rd_mux[ansir_pkg::ST_DUPLEX] = phy_resolved.full_duplex;
        rd_mux[ansir_pkg::ST_PAUSE]  = phy_resolved.pause_enabled;
        rd_mux[ansir_pkg::EV_N-1:0]  = st_ff.stat;
      end
      ansir_pkg::OFS_IRQ_EN:
      begin
        rd_mux[ansir_pkg::EV_N-1:0] = st_ff.irq_en;
      end
      default:
      begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    if (ce)
    begin
      // Read data is captured in setup; the access edge clears only what
      // was captured, so an event that lands between the two is kept
      if (setup_ph && !pwrite)
      begin
        nxt_st.rdata = {16'h0000, rd_mux};
      end

      if (rd_take && (paddr == ansir_pkg::OFS_EXPAND))
      begin
        nxt_st.exp_fault = st_ff.exp_fault && !st_ff.rdata[ansir_pkg::EX_PD_FAULT];
        nxt_st.exp_page  = st_ff.exp_page && !st_ff.rdata[ansir_pkg::EX_PAGE_RX];
      end
      if (rd_take && (paddr == ansir_pkg::OFS_STATUS))
      begin
        nxt_st.stat = st_ff.stat & ~st_ff.rdata[ansir_pkg::EV_N-1:0];
      end

      if (wr_take && (paddr == ansir_pkg::OFS_MODE))
      begin
        nxt_st.long_sq = pwdata[ansir_pkg::MC_LONG_SQ];
      end
      if (wr_take && (paddr == ansir_pkg::OFS_IRQ_EN))
      begin
        nxt_st.irq_en = pwdata[ansir_pkg::EV_N-1:0];
      end

      // Events set after any clear, so a set in the clearing cycle wins
      nxt_st.stat = nxt_st.stat | set_vec;
      if (phy_events.parallel_detect_fault)
      begin
        nxt_st.exp_fault = 1'b1;
      end

      if (phy_events.page_received_event)
      begin
        nxt_st.exp_page = 1'b1;
        nxt_st.lp_an   = 1'b1;
        nxt_st.lp_nxt  = partner_code_word[ansir_pkg::PA_NEXT_PAGE];
        nxt_st.lp_rf   = partner_code_word[ansir_pkg::PA_RFAULT];
        nxt_st.lp_abil = partner_code_word[ansir_pkg::PA_ABIL_HI:ansir_pkg::PA_ABIL_LO];
        nxt_st.lp_sel  = partner_code_word[ansir_pkg::PA_SEL_HI:0];
      end
      if (phy_events.code_word_ack_event)
      begin
        nxt_st.lp_ack = 1'b1;
      end

      // Counter restarts each time the limit is reached
      if (phy_events.rx_error_packet)
      begin
        nxt_st.err_cnt = err_full ? 7'h00 : st_ff.err_cnt + 7'h01;
      end

      nxt_st.irq = |(nxt_st.stat & nxt_st.irq_en);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= ST_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata             = st_ff.rdata;
  assign long_cable_squelch = st_ff.long_sq;
  assign xcvr_irq           = st_ff.irq;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ack_latch: assert property (
    ce && phy_events.code_word_ack_event |=> st_ff.lp_ack ##1 st_ff.lp_ack)
    else $error("partner acknowledge did not latch");

  a_fault_both: assert property (
    ce && phy_events.parallel_detect_fault
    |=> st_ff.exp_fault && st_ff.stat[ansir_pkg::EV_PD_FAULT])
    else $error("parallel detect fault not latched in both registers");

  a_local_np_zero: assert property (
    ce && setup_ph && !pwrite && paddr == ansir_pkg::OFS_EXPAND
    |=> !prdata[ansir_pkg::EX_LOCAL_NXT])
    else $error("local next page bit read as one");

  a_squelch_write: assert property (
    wr_take && paddr == ansir_pkg::OFS_MODE
    |=> long_cable_squelch == $past(pwdata[ansir_pkg::MC_LONG_SQ]))
    else $error("long cable squelch did not follow the write");

  a_squelch_hold: assert property (
    !(wr_take && paddr == ansir_pkg::OFS_MODE) |=> $stable(long_cable_squelch))
    else $error("long cable squelch changed without a write");

  a_status_clear: assert property (
    rd_take && paddr == ansir_pkg::OFS_STATUS && st_ff.rdata[ansir_pkg::EV_DONE]
    && !phy_events.autoneg_done_event |=> !st_ff.stat[ansir_pkg::EV_DONE])
    else $error("autoneg done flag not cleared by read");

  a_event_hold: assert property (
    st_ff.stat[ansir_pkg::EV_LINK_DOWN] && !(rd_take && paddr == ansir_pkg::OFS_STATUS)
    |=> st_ff.stat[ansir_pkg::EV_LINK_DOWN])
    else $error("link down flag dropped without a read");

  a_rxerr_cause: assert property (
    !st_ff.stat[ansir_pkg::EV_RXERR] ##1 st_ff.stat[ansir_pkg::EV_RXERR]
    |-> $past(phy_events.rx_error_packet)
    && $past(st_ff.err_cnt) == ansir_pkg::ERR_LIMIT - 7'h01)
    else $error("receive error flag set before the limit");

  // A status read or an enable write in the same cycle may rightly drop the request
  a_irq_raise: assert property (
    ce && (st_ff.stat & st_ff.irq_en) != 7'h00
    && !(rd_take && paddr == ansir_pkg::OFS_STATUS)
    && !(wr_take && paddr == ansir_pkg::OFS_IRQ_EN) |=> xcvr_irq)
    else $error("enabled status bit did not raise the interrupt");

  a_irq_quiet: assert property (
    xcvr_irq |-> $past((nxt_st.stat & nxt_st.irq_en) != 7'h00))
    else $error("interrupt raised with no enabled status bit");

  a_irq_masked: assert property (
    st_ff.irq_en == 7'h00 |-> !xcvr_irq)
    else $error("interrupt raised with every enable clear");

  a_page_load: assert property (
    ce && phy_events.page_received_event
    |=> st_ff.lp_abil == $past(partner_code_word[ansir_pkg::PA_ABIL_HI:ansir_pkg::PA_ABIL_LO])
    && st_ff.lp_sel == $past(partner_code_word[ansir_pkg::PA_SEL_HI:0]))
    else $error("partner abilities not loaded from the page");

  a_rfault_load: assert property (
    ce && phy_events.page_received_event
    |=> st_ff.lp_rf == $past(partner_code_word[ansir_pkg::PA_RFAULT]))
    else $error("partner remote fault not loaded from the page");

  a_page_flag: assert property (
    ce && phy_events.page_received_event |=> st_ff.exp_page && st_ff.lp_an)
    else $error("page received not latched in expansion");

  a_page_event: assert property (
    ce && phy_events.page_received_event |=> st_ff.stat[ansir_pkg::EV_PAGE])
    else $error("page received not latched in status");

  a_fault_clear: assert property (
    rd_take && paddr == ansir_pkg::OFS_EXPAND && st_ff.rdata[ansir_pkg::EX_PD_FAULT]
    && !phy_events.parallel_detect_fault |=> !st_ff.exp_fault)
    else $error("parallel detect fault not cleared by read");

  a_rfault_latch: assert property (
    ce && phy_events.remote_fault_event |=> st_ff.stat[ansir_pkg::EV_RFAULT])
    else $error("remote fault not latched in status");

  a_ack_event: assert property (
    ce && phy_events.code_word_ack_event |=> st_ff.stat[ansir_pkg::EV_ACK])
    else $error("acknowledged code word not latched in status");

  a_link_latch: assert property (
    ce && phy_events.link_down_event |=> st_ff.stat[ansir_pkg::EV_LINK_DOWN])
    else $error("link down not latched in status");

  a_done_latch: assert property (
    ce && phy_events.autoneg_done_event |=> st_ff.stat[ansir_pkg::EV_DONE])
    else $error("autoneg done not latched in status");

  // Events that arrive while frozen are lost on purpose
  a_freeze_hold: assert property (
    !ce |=> $stable(st_ff))
    else $error("state changed while the clock enable was low");

  a_speed_live: assert property (
    ce && setup_ph && !pwrite && paddr == ansir_pkg::OFS_STATUS
    |=> prdata[ansir_pkg::ST_SPEED] == $past(phy_resolved.speed_100)
    && prdata[ansir_pkg::ST_DUPLEX] == $past(phy_resolved.full_duplex))
    else $error("speed or duplex not reported");

  a_pause_live: assert property (
    ce && setup_ph && !pwrite && paddr == ansir_pkg::OFS_STATUS
    |=> prdata[ansir_pkg::ST_PAUSE] == $past(phy_resolved.pause_enabled))
    else $error("pause setting not reported");

  a_enable_reserved: assert property (
    ce && setup_ph && !pwrite && paddr == ansir_pkg::OFS_IRQ_EN
    |=> prdata[ansir_pkg::APB_DW-1:ansir_pkg::EV_N] == '0)
    else $error("reserved enable bits read as one");

endmodule

// file: testbench/ansir_partner_model.sv
// Remote link partner: turns bench requests into event pulses and page words
`timescale 1ns/1ps

module ansir_partner_model
(
  // Clock
  input  logic                  pclk,
  // Bench requests
  input  ansir_pkg::ansir_evt_t req,
  input  logic [15:0]           word,
  // Toward the register bank
  output ansir_pkg::ansir_evt_t phy_events = '0,
  output logic [15:0]           partner_code_word = 16'h0000
);
  // Outside a page the word toggles every cycle, so a stale sample never passes
  always_ff @(posedge pclk)
  begin
    phy_events <= req;
    if (req.page_received_event)
      partner_code_word <= word;
    else
      partner_code_word <= ~partner_code_word;
  end
endmodule

// file: testbench/ansir_regs_tb_top.sv
// Self-checking bench of the auto-negotiation status and interrupt registers
`timescale 1ns/1ps

module ansir_regs_tb_top;
  typedef struct packed {
    logic [6:0]  evt;
    logic [15:0] st;
    logic [15:0] ex;
  } ansir_row_t;
  logic                              pclk = 1'b0;
  logic                              presetn = 1'b0;
  logic                              ce = 1'b1;
  logic                              psel = 1'b0;
  logic                              penable = 1'b0;
  logic                              pwrite = 1'b0;
  logic [ansir_pkg::APB_AW-1:0]      paddr = 8'h00;
  logic [ansir_pkg::APB_DW-1:0]      pwdata = 32'h0000_0000;
  logic [ansir_pkg::APB_DW-1:0]      prdata;
  logic                              pready;
  logic                              pslverr;
  logic [15:0]                       code_word;
  ansir_pkg::ansir_evt_t             phy_events;
  ansir_pkg::ansir_evt_t             req = '0;
  ansir_pkg::ansir_res_t             phy_resolved = '0;
  logic                              long_cable_squelch;
  logic                              xcvr_irq;
  logic [31:0]                       rd;
  logic                              err;
  int                                num_errors = 0;
  int                                checks = 0;
  ansir_row_t                        rows [6];

  ansir_regs ansir_regs_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .partner_code_word(code_word),
    .phy_events(phy_events), .phy_resolved(phy_resolved),
    .long_cable_squelch(long_cable_squelch), .xcvr_irq(xcvr_irq));

  ansir_partner_model ansir_partner_model_inst (.pclk(pclk), .req(req), .word(16'ha5a1),
    .phy_events(phy_events), .partner_code_word(code_word));

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      num_errors++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, {16'h0000, e});
    chk({nm, " slverr"}, {31'h0000_0000, err}, 32'h0000_0000);
  endtask

  // Partner pulse lands in the register two edges after the request
  task automatic ev(input logic [6:0] m);
    @(posedge pclk);
    req <= m;
    @(posedge pclk);
    req <= '0;
    @(posedge pclk);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #800000;
    num_errors++;
    summarize();
  end

  initial
  begin
    rows = '{'{7'h02, 16'h0002, 16'h000b}, '{7'h40, 16'h0040, 16'h0009},
             '{7'h20, 16'h0020, 16'h0009}, '{7'h10, 16'h0010, 16'h0009},
             '{7'h08, 16'h0008, 16'h0009}, '{7'h04, 16'h0004, 16'h0019}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("squelch rst", {31'h0000_0000, long_cable_squelch}, 32'h0000_0000);
    rdc("partner rst", ansir_pkg::OFS_PARTNER, 16'h0001);
    rdc("expand rst", ansir_pkg::OFS_EXPAND, 16'h0000);
    rdc("status rst", ansir_pkg::OFS_STATUS, 16'h0000);
    apb(1'b0, 8'he0, 32'h0000_0000);
    chk("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
    chk("unmapped rd", rd, 32'h0000_0000);
    apb(1'b1, ansir_pkg::OFS_MODE, 32'hffff_ffff);
    rdc("mode rw", ansir_pkg::OFS_MODE, 16'h0800);
    chk("squelch on", {31'h0000_0000, long_cable_squelch}, 32'h0000_0001);
    apb(1'b1, ansir_pkg::OFS_IRQ_EN, 32'hffff_ffff);
    rdc("enable rw", ansir_pkg::OFS_IRQ_EN, 16'h007f);
    apb(1'b1, ansir_pkg::OFS_STATUS, 32'hffff_ffff);
    rdc("status ro", ansir_pkg::OFS_STATUS, 16'h0000);
    foreach (rows[i])
    begin
      ev(rows[i].evt);
      chk("irq set", {31'h0000_0000, xcvr_irq}, 32'h0000_0001);
      rdc("status ev", ansir_pkg::OFS_STATUS, rows[i].st);
      rdc("expand ev", ansir_pkg::OFS_EXPAND, rows[i].ex);
      rdc("status clr", ansir_pkg::OFS_STATUS, 16'h0000);
      chk("irq clr", {31'h0000_0000, xcvr_irq}, 32'h0000_0000);
    end
    rdc("partner word", ansir_pkg::OFS_PARTNER, 16'he5a1);
    apb(1'b1, ansir_pkg::OFS_IRQ_EN, 32'h0000_0000);
    ev(7'h10);
    chk("irq masked", {31'h0000_0000, xcvr_irq}, 32'h0000_0000);
    apb(1'b1, ansir_pkg::OFS_IRQ_EN, 32'h0000_0010);
    @(posedge pclk);
    #1;
    chk("irq unmasked", {31'h0000_0000, xcvr_irq}, 32'h0000_0001);
    rdc("status held", ansir_pkg::OFS_STATUS, 16'h0010);
    // Event lands on the clearing edge of a read: the set must win
    ev(7'h40);
    fork
      apb(1'b0, ansir_pkg::OFS_STATUS, 32'h0000_0000);
      ev(7'h40);
    join
    chk("done seen", rd, 32'h0000_0040);
    rdc("done kept", ansir_pkg::OFS_STATUS, 16'h0040);
    rdc("done clr", ansir_pkg::OFS_STATUS, 16'h0000);
    // Frozen block stalls the bus and drops the event
    @(posedge pclk);
    ce <= 1'b0;
    ev(7'h20);
    chk("pready frozen", {31'h0000_0000, pready}, 32'h0000_0000);
    @(posedge pclk);
    ce <= 1'b1;
    rdc("frozen lost", ansir_pkg::OFS_STATUS, 16'h0000);
    @(posedge pclk);
    phy_resolved <= 3'b111;
    repeat (63) ev(7'h01);
    rdc("err below", ansir_pkg::OFS_STATUS, 16'h0380);
    ev(7'h01);
    rdc("err full", ansir_pkg::OFS_STATUS, 16'h0381);
    rdc("err clr", ansir_pkg::OFS_STATUS, 16'h0380);
    @(posedge pclk);
    phy_resolved <= 3'b010;
    presetn      <= 1'b0;
    @(posedge pclk);
    presetn      <= 1'b1;
    rdc("partner rst2", ansir_pkg::OFS_PARTNER, 16'h0001);
    rdc("mode rst2", ansir_pkg::OFS_MODE, 16'h0000);
    rdc("duplex only", ansir_pkg::OFS_STATUS, 16'h0100);
    summarize();
  end
endmodule
